// ---- pkg/dqb_pkg.sv ----
// Shared constants and types for the burst sequencer
// What this block does
// - Ready rises within 4097 master cycles after wake is sampled high.
// - First bit clock rise comes three master cycles after request sampled high.
// - Ramp-down lasts seven and a half bit clock periods after the last symbol.
// - Ready rises within 30 master cycles of the final bit clock fall.
// - Bit clock runs at 42 kHz; data is captured on its falling edge.
// - Request high starts the envelope ramp-up, low starts the ramp-down.
// - Wake low puts the block asleep; wake high starts offset calibration.
// - Delayed copy of the request matches the modulator pipeline latency.
`default_nettype none
package dqb_pkg;
    localparam longint CLK_HZ = 200000000;
    localparam longint MCLK_HZ = 2688000;
    // Master-cycle tick divider; rounded down so the tick is never slower
    localparam int TICK_DIV = int'(CLK_HZ / MCLK_HZ);
    localparam int CAL_TICKS = 4096;
    localparam int LEAD_TICKS = 3;
    localparam int BIT_PERIOD_TICKS = 64;
    localparam int BIT_HIGH_TICKS = 32;
    // Seven and a half bit periods, in master cycles
    localparam int RAMPDN_TICKS = (BIT_PERIOD_TICKS * 15) / 2;
    localparam int PIPE_LAT_TICKS = 64;
    localparam int CNT_W = 13;
    localparam int PHASE_W = 6;
    localparam logic [PHASE_W-1:0] PHASE_FALL = 6'h20;

    typedef enum logic [2:0] {
        DQB_SLEEP = 3'b000,
        DQB_CAL = 3'b001,
        DQB_IDLE = 3'b010,
        DQB_LEAD = 3'b011,
        DQB_RUN = 3'b100,
        DQB_RAMPDN = 3'b101,
        DQB_TAIL = 3'b110
    } dqb_state_t;

    typedef struct packed {
        logic data;
        logic strobe;
    } dqb_bit_t;

    typedef struct packed {
        logic ramp_up;
        logic ramp_down;
    } dqb_env_t;
endpackage : dqb_pkg
`default_nettype wire

// ---- core/dqb_delay_mem.sv ----
// Tick-stepped delay line holding the burst request history
`default_nettype none
module dqb_delay_mem #(
    parameter int DEPTH = 64
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Stream
    input wire logic shift_en,
    input wire logic din,
    output logic dout
);
    logic [DEPTH-1:0] line_r;
    logic [DEPTH-1:0] line_nxt;
    logic dout_nxt;

    always_comb begin
        line_nxt = line_r;
        if (shift_en) begin
            line_nxt = {line_r[DEPTH-2:0], din};
        end
        // Output moves only on the tick, so the delay is a full DEPTH ticks
        dout_nxt = shift_en ? line_r[DEPTH-1] : dout;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            line_r <= '0;
            dout <= 1'b0;
        end else begin
            line_r <= line_nxt;
            dout <= dout_nxt;
        end
    end
endmodule : dqb_delay_mem
`default_nettype wire

// ---- core/dqb_burst_seq.sv ----
// Transmit burst sequencer: wake calibration, bit clock, ramp control
`default_nettype none
module dqb_burst_seq
    import dqb_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_TICKS,
    parameter int PIPE_LAT = PIPE_LAT_TICKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Controller pins
    input wire logic wake,
    input wire logic burst_request,
    input wire logic serial_bit_in,
    // Status and timing outputs
    output logic ready,
    output logic symbol_bit_clock,
    output logic burst_delayed_out,
    output logic asleep,
    // Captured data and envelope control
    output dqb_bit_t bit_out,
    output dqb_env_t envelope
);
    localparam logic [6:0] DIV_LAST = 7'(TICK_DIV - 1);
    localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);
    localparam logic [CNT_W-1:0] LEAD_LAST = CNT_W'(LEAD_TICKS);
    localparam logic [CNT_W-1:0] RAMPDN_LAST = CNT_W'(RAMPDN_TICKS - 1);

    // Pin synchronisers: first stage feeds only the second
    logic [2:0] meta_r;
    logic [2:0] sync_r;
    logic wake_s;
    logic req_s;
    logic data_s;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_r <= 3'h0;
            sync_r <= 3'h0;
        end else begin
            meta_r <= {wake, burst_request, serial_bit_in};
            sync_r <= meta_r;
        end
    end
    assign wake_s = sync_r[2];
    assign req_s = sync_r[1];
    assign data_s = sync_r[0];

    // Master-cycle tick divider
    logic [6:0] div_r;
    logic [6:0] div_nxt;
    logic tick;

    always_comb begin
        tick = (div_r == DIV_LAST);
        div_nxt = tick ? 7'h00 : div_r + 7'h01;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            div_r <= 7'h00;
        end else begin
            div_r <= div_nxt;
        end
    end

    // Sequencer
    dqb_state_t state_r;
    dqb_state_t state_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [PHASE_W-1:0] phase_r;
    logic [PHASE_W-1:0] phase_nxt;
    logic last_pend_r;
    logic last_pend_nxt;
    logic bitclk_nxt;
    logic ready_nxt;
    dqb_bit_t bit_nxt;
    dqb_env_t env_nxt;
    logic fall_now;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        phase_nxt = phase_r;
        last_pend_nxt = last_pend_r;
        bit_nxt = '{data: bit_out.data, strobe: 1'b0};
        fall_now = 1'b0;
        if (tick && (state_r == DQB_RUN || state_r == DQB_RAMPDN || state_r == DQB_TAIL)) begin
            phase_nxt = phase_r + 6'h01;
            fall_now = (phase_nxt == PHASE_FALL);
        end
        if (!wake_s) begin
            state_nxt = DQB_SLEEP;
            cnt_nxt = '0;
            phase_nxt = '0;
            last_pend_nxt = 1'b0;
        end else if (tick) begin
            unique case (state_r)
                DQB_SLEEP: begin
                    state_nxt = DQB_CAL;
                    cnt_nxt = '0;
                end
                DQB_CAL: begin
                    cnt_nxt = cnt_r + 1'b1;
                    if (cnt_r == CAL_LAST) begin
                        state_nxt = DQB_IDLE;
                    end
                end
                DQB_IDLE: begin
                    if (req_s) begin
                        state_nxt = DQB_LEAD;
                        cnt_nxt = CNT_W'(1);
                    end
                end
                DQB_LEAD: begin
                    cnt_nxt = cnt_r + 1'b1;
                    if (cnt_r == LEAD_LAST) begin
                        state_nxt = DQB_RUN;
                        phase_nxt = '0;
                        last_pend_nxt = 1'b0;
                    end
                end
                DQB_RUN: begin
                    // Request low marks the next captured bit as the last symbol
                    if (!req_s) begin
                        last_pend_nxt = 1'b1;
                    end
                    if (fall_now) begin
                        bit_nxt = '{data: data_s, strobe: 1'b1};
                        if (last_pend_r || !req_s) begin
                            state_nxt = DQB_RAMPDN;
                            cnt_nxt = '0;
                        end
                    end
                end
                DQB_RAMPDN: begin
                    cnt_nxt = cnt_r + 1'b1;
                    if (cnt_r == RAMPDN_LAST) begin
                        state_nxt = DQB_TAIL;
                    end
                end
                DQB_TAIL: begin
                    // Finish the bit clock period so the line rests low
                    if (fall_now) begin
                        state_nxt = DQB_IDLE;
                    end
                end
                default: begin
                    state_nxt = DQB_SLEEP;
                end
            endcase
        end
        bitclk_nxt = (state_nxt == DQB_RUN || state_nxt == DQB_RAMPDN || state_nxt == DQB_TAIL)
            && !phase_nxt[PHASE_W-1];
        ready_nxt = (state_nxt == DQB_IDLE);
        env_nxt.ramp_up = (state_nxt == DQB_LEAD || state_nxt == DQB_RUN);
        env_nxt.ramp_down = (state_nxt == DQB_RAMPDN);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= DQB_SLEEP;
            cnt_r <= '0;
            phase_r <= '0;
            last_pend_r <= 1'b0;
            symbol_bit_clock <= 1'b0;
            ready <= 1'b0;
            asleep <= 1'b1;
            bit_out <= '0;
            envelope <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            phase_r <= phase_nxt;
            last_pend_r <= last_pend_nxt;
            symbol_bit_clock <= bitclk_nxt;
            ready <= ready_nxt;
            asleep <= (state_nxt == DQB_SLEEP);
            bit_out <= bit_nxt;
            envelope <= env_nxt;
        end
    end

    // Delayed request copy for the RF amplifier switch
    logic delayed_raw;
    logic delayed_nxt;

    dqb_delay_mem #(
        .DEPTH(PIPE_LAT)
    ) u_delay (
        .clock(clock),
        .rst_n(rst_n),
        .shift_en(tick),
        .din(req_s && wake_s),
        .dout(delayed_raw)
    );

    always_comb begin
        delayed_nxt = delayed_raw && wake_s;
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            burst_delayed_out <= 1'b0;
        end else begin
            burst_delayed_out <= delayed_nxt;
        end
    end
endmodule : dqb_burst_seq
`default_nettype wire

// ---- tb/dqb_assertions.sv ----
// Port checker for the burst sequencer, bound into the core
`default_nettype none
module dqb_checker
    import dqb_pkg::*;
#(
    parameter int CAL_CYCLES = CAL_TICKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Watched outputs
    input wire logic ready,
    input wire logic symbol_bit_clock,
    input wire logic asleep,
    input wire dqb_bit_t bit_out,
    input wire dqb_env_t envelope
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL_LO = CAL_CYCLES * TICK_DIV - 1;
    localparam int CAL_HI = CAL_CYCLES * TICK_DIV + 1;
    localparam int LEAD_LO = LEAD_TICKS * TICK_DIV - 1;
    localparam int LEAD_HI = LEAD_TICKS * TICK_DIV + 1;
    logic [15:0] hi_r, hi_nxt, rd_r, rd_nxt;
    // Calibration is far too long for a delay range, so it is counted instead
    logic [19:0] cal_r, cal_nxt;
    logic woke_r, woke_nxt;
    always_comb begin
        hi_nxt = symbol_bit_clock ? hi_r + 16'h1 : 16'h0;
        rd_nxt = envelope.ramp_down ? rd_r + 16'h1 : 16'h0;
        cal_nxt = asleep ? 20'h0 : cal_r + 20'h1;
        woke_nxt = asleep ? 1'b1 : (ready ? 1'b0 : woke_r);
    end
    always_ff @(posedge clock) begin
        hi_r <= rst_n ? hi_nxt : 16'h0;
        rd_r <= rst_n ? rd_nxt : 16'h0;
        cal_r <= rst_n ? cal_nxt : 20'h0;
        woke_r <= rst_n ? woke_nxt : 1'b0;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_sleep_idle: assert property (asleep |-> !ready && !symbol_bit_clock)
        else $error("ready or bit clock active while asleep");
    a_cal_time: assert property ($rose(ready) && woke_r |-> cal_r inside {[CAL_LO:CAL_HI]})
        else $error("calibration end out of time");
    a_ramp_excl: assert property (!(envelope.ramp_up && envelope.ramp_down))
        else $error("ramp up and down together");
    a_ready_drop: assert property ($rose(envelope.ramp_up) |-> $fell(ready))
        else $error("ready not dropped at burst start");
    a_first_rise: assert property ($rose(envelope.ramp_up) |->
        ##[LEAD_LO:LEAD_HI] $rose(symbol_bit_clock))
        else $error("first bit clock rise mistimed");
    a_bit_high: assert property ($fell(symbol_bit_clock) && !asleep |-> hi_r == 16'h940)
        else $error("bit clock high time wrong");
    a_strobe_low: assert property (bit_out.strobe |->
        !symbol_bit_clock && $past(envelope.ramp_up))
        else $error("strobe outside a falling bit clock in burst");
    a_ramp_len: assert property ($fell(envelope.ramp_down) && !asleep |-> rd_r == 16'h8ac0)
        else $error("ramp down length wrong");
    c_ready: cover property ($rose(ready));
    c_strobe: cover property (bit_out.strobe);
    c_ramp_end: cover property ($fell(envelope.ramp_down));
endmodule : dqb_checker
bind dqb_burst_seq dqb_checker #(.CAL_CYCLES(CAL_CYCLES)) u_chk (.clock(clock), .rst_n(rst_n),
    .ready(ready), .symbol_bit_clock(symbol_bit_clock), .asleep(asleep), .bit_out(bit_out),
    .envelope(envelope));
`default_nettype wire

// ---- tb/dqb_ctrl_model.sv ----
// Controller model: presents transmit bits on the serial input
`default_nettype none
module dqb_ctrl_model (
    // Clock and bit clock
    input wire logic clock,
    input wire logic symbol_bit_clock,
    // Bits to send, lowest first
    input wire logic [7:0] pattern,
    output logic serial_bit_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_q = 1'b0;
    logic [2:0] idx = 3'h0;
    // Change on the rise so the bit is stable half a period before the capturing fall
    always @(posedge clock) begin
        clk_q <= symbol_bit_clock;
        if (symbol_bit_clock && !clk_q) begin
            serial_bit_in <= pattern[idx];
            idx <= idx + 3'h1;
        end
    end
endmodule : dqb_ctrl_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the burst sequencer
`default_nettype none
module tb import dqb_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CAL = 8;
    localparam int LAT = 4;
    localparam int RD_SPAN = (RAMPDN_TICKS + BIT_HIGH_TICKS) * TICK_DIV;
    localparam logic [7:0] PAT = 8'h05;
    logic clock = 1'b0, rst_n = 1'b0, wake = 1'b0, burst_request = 1'b0;
    logic serial_bit_in, ready, symbol_bit_clock, burst_delayed_out, asleep;
    dqb_bit_t bit_out;
    dqb_env_t envelope;
    int n_fail = 0, n_tests = 0, cyc = 0, req_at = 0, bdo_at = 0;
    dqb_burst_seq #(.CAL_CYCLES(CAL), .PIPE_LAT(LAT)) dut (.clock(clock), .rst_n(rst_n),
        .wake(wake), .burst_request(burst_request), .serial_bit_in(serial_bit_in),
        .ready(ready), .symbol_bit_clock(symbol_bit_clock), .burst_delayed_out(burst_delayed_out),
        .asleep(asleep), .bit_out(bit_out), .envelope(envelope));
    dqb_ctrl_model u_ctrl (.clock(clock), .symbol_bit_clock(symbol_bit_clock), .pattern(PAT),
        .serial_bit_in(serial_bit_in));
    initial begin
        forever #2.5 clock = ~clock;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        while (s !== 1'b1 && n < 50000) begin
            @(posedge clock);
            n++;
        end
    endtask : wait_hi
    task automatic t_wake;
        int n;
        check(asleep, 1'b1);
        @(posedge clock);
        wake <= 1'b1;
        wait_hi(ready, n);
        check(n inside {[CAL * TICK_DIV : (CAL + 1) * TICK_DIV + 8]}, 1'b1);
        check(asleep, 1'b0);
        $display("wake test done");
    endtask : t_wake
    task automatic t_burst;
        int n, t_hi;
        @(posedge clock);
        burst_request <= 1'b1;
        req_at = cyc;
        wait_hi(symbol_bit_clock, n);
        check(n inside {[LEAD_TICKS * TICK_DIV : (LEAD_TICKS + 1) * TICK_DIV + 6]}, 1'b1);
        check({ready, envelope.ramp_up}, 2'b01);
        for (int i = 0; i < 3; i++) begin
            n = 0;
            while (bit_out.strobe !== 1'b1 && n < 6000) begin
                @(posedge clock);
                n++;
            end
            check(bit_out.data, PAT[i]);
            // Drop the request two ticks before the next fall, inside the end window
            if (i == 1) repeat ((BIT_PERIOD_TICKS - 2) * TICK_DIV) @(posedge clock);
            if (i == 1) burst_request <= 1'b0;
            @(posedge clock);
        end
        check({envelope.ramp_up, envelope.ramp_down}, 2'b01);
        check((bdo_at - req_at) inside {[LAT * TICK_DIV : (LAT + 1) * TICK_DIV + 8]}, 1'b1);
        n = 0;
        t_hi = 0;
        while (ready !== 1'b1 && n < 45000) begin
            @(posedge clock);
            n++;
            if (symbol_bit_clock) t_hi = n;
        end
        check(n inside {[RD_SPAN - 80 : RD_SPAN + 80]}, 1'b1);
        check((n - t_hi) <= 30 * TICK_DIV, 1'b1);
        $display("burst test done");
    endtask : t_burst
    task automatic t_sleep;
        @(posedge clock);
        wake <= 1'b0;
        repeat (6) @(posedge clock);
        check({asleep, ready, envelope}, 4'h8);
        $display("sleep test done");
    endtask : t_sleep
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (burst_delayed_out === 1'b1 && bdo_at == 0) bdo_at = cyc;
        if (cyc == 90000) begin
            n_fail++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clock);
        check({ready, symbol_bit_clock, asleep}, 3'h1);
        rst_n <= 1'b1;
        t_wake();
        t_burst();
        t_sleep();
        t_wake();
        finish_test();
    end
endmodule : tb
`default_nettype wire
